// *** src/interrupt_flag_mask_unit.v ***
`timescale 1ns/1ps
`include "irq_unit_defines.vh"
module interrupt_flag_mask_unit (
    input  wire       clock,            // system clock, 10 MHz
    input  wire       rst,              // initial reset, async high
    input  wire       ce,               // clock enable
    input  wire [7:0] addr,             // data bus address
    input  wire [3:0] wdata,            // data bus write data
    input  wire       wr,               // write strobe
    input  wire       rd,               // read strobe
    output reg  [3:0] rdata_q,          // read data
    input  wire [3:0] input_pin_group,  // pins, async
    input  wire       single_input_pin, // pin, async
    input  wire       timer_2hz,        // clock-timer 2 Hz level
    input  wire       timer_8hz,        // clock-timer 8 Hz level
    input  wire       timer_32hz,       // clock-timer 32 Hz level
    input  wire       sw_1hz,           // stopwatch 1 Hz level
    input  wire       sw_10hz,          // stopwatch 10 Hz level
    input  wire       core_irq_enable_flag, // core interrupt enable
    input  wire       halt_exec,        // halt instruction pulse
    input  wire       supply_low_result, // supply check result
    output wire       irq_req,          // interrupt request to core
    output wire [3:0] vector_step,      // vector step, page 1
    output wire [3:0] vector_page,      // vector page
    output wire       core_clock_en,    // core clock gate
    output reg        halted_q,         // core halted
    output wire       heavy_load_mode,  // heavy load protection
    output wire       supply_check_on,  // supply check on
    output wire       display_drive_switch // lcd drive switch
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    reg  [3:0] grp_sync1_q;
    reg  [3:0] grp_sync2_q;
    reg  [3:0] grp_prev_q;
    reg        pin_sync1_q;
    reg        pin_sync2_q;
    reg        pin_prev_q;
    reg  [4:0] tick_sync1_q;
    reg  [4:0] tick_sync2_q;
    reg  [4:0] tick_prev_q;
    wire [4:0] tick_raw;

    // taps packed as slow, mid, fast, second, tenth from bit 0 up
    assign tick_raw = {sw_10hz, sw_1hz, timer_32hz, timer_8hz, timer_2hz};

    // pin group: two flops, a third keeps the last sample for compare
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            grp_sync1_q <= `NIBBLE_RESET;
            grp_sync2_q <= `NIBBLE_RESET;
            grp_prev_q  <= `NIBBLE_RESET;
        end else if (ce) begin
            grp_sync1_q <= input_pin_group;
            grp_sync2_q <= grp_sync1_q;
            grp_prev_q  <= grp_sync2_q;
        end
    end

    // single pin: same chain, also feeds the level readback
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sync1_q <= 1'b0;
            pin_sync2_q <= 1'b0;
            pin_prev_q  <= 1'b0;
        end else if (ce) begin
            pin_sync1_q <= single_input_pin;
            pin_sync2_q <= pin_sync1_q;
            pin_prev_q  <= pin_sync2_q;
        end
    end

    // timebase taps: fall detection needs the previous sample
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_sync1_q <= `TAP_RESET;
            tick_sync2_q <= `TAP_RESET;
            tick_prev_q  <= `TAP_RESET;
        end else if (ce) begin
            tick_sync1_q <= tick_raw;
            tick_sync2_q <= tick_sync1_q;
            tick_prev_q  <= tick_sync2_q;
        end
    end

    wire [3:0] grp_now   = grp_sync2_q;
    wire [3:0] grp_prev  = grp_prev_q;
    wire       pin_now   = pin_sync2_q;
    wire       pin_prev  = pin_prev_q;
    wire [4:0] tick_now  = tick_sync2_q;
    wire [4:0] tick_prev = tick_prev_q;

    // ------------------------------------------------------------------
    // supply check result synchroniser
    // ------------------------------------------------------------------
    // result comes from an analog comparator, not from this clock
    reg supply_sync1_q;
    reg supply_sync2_q;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_sync1_q <= 1'b0;
            supply_sync2_q <= 1'b0;
        end else if (ce) begin
            supply_sync1_q <= supply_low_result;
            supply_sync2_q <= supply_sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    reg [3:0] pin_group_edge_bits_q;
    reg [3:0] pin_group_enable_bits_q;
    reg [3:0] sw_en_supply_q;
    reg       single_pin_enable_q;
    reg       single_pin_edge_bit_q;
    reg [3:0] timer_en_lcd_q;

    // writes land at the edge that samples the strobe
    wire wr_ok = ce & wr;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_group_edge_bits_q   <= `NIBBLE_RESET;
            pin_group_enable_bits_q <= `NIBBLE_RESET;
            sw_en_supply_q          <= `NIBBLE_RESET;
            single_pin_enable_q     <= 1'b0;
            single_pin_edge_bit_q   <= 1'b0;
            timer_en_lcd_q          <= `NIBBLE_RESET;
        end else if (wr_ok) begin
            case (addr)
                `ADDR_PIN_GROUP_EDGE: begin
                    pin_group_edge_bits_q <= wdata;
                end
                `ADDR_PIN_GROUP_EN: begin
                    pin_group_enable_bits_q <= wdata;
                end
                `ADDR_SW_EN_SUPPLY: begin
                    // supply result bit is read-only
                    sw_en_supply_q[`BIT_D3] <= wdata[`BIT_D3];
                    sw_en_supply_q[`BIT_D2] <= wdata[`BIT_D2];
                    sw_en_supply_q[`BIT_D1] <= wdata[`BIT_D1];
                    sw_en_supply_q[`BIT_D0] <= wdata[`BIT_D0];
                end
                `ADDR_SINGLE_PIN_CTL: begin
                    single_pin_enable_q   <= wdata[`BIT_D2];
                    single_pin_edge_bit_q <= wdata[`BIT_D1];
                end
                `ADDR_TIMER_EN_LCD: begin
                    timer_en_lcd_q <= wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign heavy_load_mode      = sw_en_supply_q[`BIT_D3];
    assign supply_check_on      = sw_en_supply_q[`BIT_D2];
    assign display_drive_switch = timer_en_lcd_q[`BIT_D3];

    // ------------------------------------------------------------------
    // factor events
    // ------------------------------------------------------------------
    // falling edges of the timebase taps, masks do not gate them
    wire [4:0] tick_fall = tick_prev & ~tick_now;

    wire fall_slow   = tick_fall[0];
    wire fall_mid    = tick_fall[1];
    wire fall_fast   = tick_fall[2];
    wire fall_second = tick_fall[3];
    wire fall_tenth  = tick_fall[4];

    // group matches edge bits on enabled pins; mismatch after match sets
    wire [3:0] grp_diff_now  = (grp_now ^ pin_group_edge_bits_q)
                               & pin_group_enable_bits_q;
    wire [3:0] grp_diff_prev = (grp_prev ^ pin_group_edge_bits_q)
                               & pin_group_enable_bits_q;
    wire       grp_miss_now  = |grp_diff_now;
    wire       grp_miss_prev = |grp_diff_prev;
    // both compares on the same edge bits avoid false sets on a write
    wire grp_event = grp_miss_now & ~grp_miss_prev;

    wire pin_rise  = pin_now & ~pin_prev;
    wire pin_fall  = ~pin_now & pin_prev;
    wire pin_event = single_pin_enable_q
                     & (single_pin_edge_bit_q ? pin_fall : pin_rise);

    // ------------------------------------------------------------------
    // factor flags
    // ------------------------------------------------------------------
    wire rd_ok       = ce & rd;
    wire clr_timer   = rd_ok & (addr == `ADDR_TIMER_FLAGS);
    wire clr_in_sw   = rd_ok & (addr == `ADDR_INPUT_SW_FLAGS);

    wire [6:0] flag_evt;
    wire [6:0] flag_clr;
    wire [6:0] flag_q;

    // order: 32 Hz, 8 Hz, 2 Hz, sw 10 Hz, sw 1 Hz, group, single pin
    assign flag_evt = {pin_event, grp_event, fall_second, fall_tenth,
                       fall_slow, fall_mid, fall_fast};
    assign flag_clr = {clr_in_sw, clr_in_sw, clr_in_sw, clr_in_sw,
                       clr_timer, clr_timer, clr_timer};

    // one sticky cell per source; a set in a clearing read survives
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_flag
            edge_flag u_flag (
                .clock    (clock),
                .rst      (rst),
                .ce       (ce),
                .event_in (flag_evt[gi]),
                .clear_in (flag_clr[gi]),
                .flag_q   (flag_q[gi])
            );
        end
    endgenerate

    wire timer_fast_flag       = flag_q[0];
    wire timer_mid_flag        = flag_q[1];
    wire timer_slow_flag       = flag_q[2];
    wire stopwatch_tenth_flag  = flag_q[3];
    wire stopwatch_second_flag = flag_q[4];
    wire pin_group_flag        = flag_q[5];
    wire single_pin_flag       = flag_q[6];

    // ------------------------------------------------------------------
    // requests and vector
    // ------------------------------------------------------------------
    // timer and stopwatch mask bits gate the request only; pin enables also gate the pin flags
    wire timer_slow_enable       = timer_en_lcd_q[`BIT_D2];
    wire timer_mid_enable        = timer_en_lcd_q[`BIT_D1];
    wire timer_fast_enable       = timer_en_lcd_q[`BIT_D0];
    wire stopwatch_second_enable = sw_en_supply_q[`BIT_D1];
    wire stopwatch_tenth_enable  = sw_en_supply_q[`BIT_D0];
    wire any_group_enable        = |pin_group_enable_bits_q;

    wire slow_request   = timer_slow_flag & timer_slow_enable;
    wire mid_request    = timer_mid_flag & timer_mid_enable;
    wire fast_request   = timer_fast_flag & timer_fast_enable;
    wire second_request = stopwatch_second_flag & stopwatch_second_enable;
    wire tenth_request  = stopwatch_tenth_flag & stopwatch_tenth_enable;

    wire single_pin_request = single_pin_flag & single_pin_enable_q;
    wire pin_group_request  = pin_group_flag & any_group_enable;
    wire timer_request      = slow_request | mid_request | fast_request;
    wire stopwatch_request  = second_request | tenth_request;

    wire [3:0] pending = {stopwatch_request, timer_request,
                          pin_group_request, single_pin_request};

    assign irq_req     = core_irq_enable_flag & (|pending);
    assign vector_step = irq_req ? pending : `VEC_NONE;
    assign vector_page = `VEC_PAGE;

    // ------------------------------------------------------------------
    // halt control
    // ------------------------------------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            halted_q <= 1'b0;
        end else if (ce) begin
            // a request in the halt cycle wins, so the core never sleeps
            if (irq_req) begin
                halted_q <= 1'b0;
            end else if (halt_exec) begin
                halted_q <= 1'b1;
            end
        end
    end

    // gate opens combinationally so the wake costs no extra cycle
    assign core_clock_en = ~halted_q | irq_req;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // assembled read words; unused bits tie low
    wire [3:0] sw_en_supply_word = {sw_en_supply_q[`BIT_D3],
                                    supply_sync2_q,
                                    sw_en_supply_q[`BIT_D1],
                                    sw_en_supply_q[`BIT_D0]};
    wire [3:0] single_pin_word   = {1'b0,
                                    single_pin_enable_q,
                                    single_pin_edge_bit_q,
                                    pin_now};
    wire [3:0] timer_flag_word   = {1'b0,
                                    timer_slow_flag,
                                    timer_mid_flag,
                                    timer_fast_flag};
    wire [3:0] input_sw_word     = {single_pin_flag,
                                    pin_group_flag,
                                    stopwatch_second_flag,
                                    stopwatch_tenth_flag};

    reg [3:0] rdata_d;
    always @* begin
        case (addr)
            `ADDR_PIN_GROUP_EDGE: rdata_d = pin_group_edge_bits_q;
            `ADDR_PIN_GROUP_EN:   rdata_d = pin_group_enable_bits_q;
            `ADDR_SW_EN_SUPPLY:   rdata_d = sw_en_supply_word;
            `ADDR_SINGLE_PIN_CTL: rdata_d = single_pin_word;
            `ADDR_TIMER_EN_LCD:   rdata_d = timer_en_lcd_q;
            `ADDR_TIMER_FLAGS:    rdata_d = timer_flag_word;
            `ADDR_INPUT_SW_FLAGS: rdata_d = input_sw_word;
            default:              rdata_d = `NIBBLE_RESET;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= `NIBBLE_RESET;
        end else if (rd_ok) begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// *** src/irq_unit_defines.vh ***
`ifndef IRQ_UNIT_DEFINES_VH
`define IRQ_UNIT_DEFINES_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_PIN_GROUP_EDGE   8'h74
`define ADDR_PIN_GROUP_EN     8'h75
`define ADDR_SW_EN_SUPPLY     8'h76
`define ADDR_SINGLE_PIN_CTL   8'h77
`define ADDR_TIMER_EN_LCD     8'h78
`define ADDR_TIMER_FLAGS      8'h79
`define ADDR_INPUT_SW_FLAGS   8'h7A

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_D0                0
`define BIT_D1                1
`define BIT_D2                2
`define BIT_D3                3

// ----------------------------------------------------------------------
// reset values and vector fields
// ----------------------------------------------------------------------
`define NIBBLE_RESET          4'h0
`define TAP_RESET             5'h00
`define VEC_PAGE              4'h1
`define VEC_NONE              4'h0

`endif

// *** src/edge_flag.v ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// one factor flag: edge set, read clear, set wins
// ----------------------------------------------------------------------
module edge_flag (
    input  wire clock,    // system clock
    input  wire rst,      // async reset
    input  wire ce,       // clock enable
    input  wire event_in, // one-cycle set pulse
    input  wire clear_in, // one-cycle read-clear pulse
    output reg  flag_q    // sticky flag
);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            if (event_in) begin
                flag_q <= 1'b1;
            end else if (clear_in) begin
                flag_q <= 1'b0;
            end
        end
    end

endmodule

// *** tb/interrupt_flag_mask_unit_properties.sv ***
`timescale 1ns/1ps
module irq_unit_checker (
    input wire       clock,                // system clock
    input wire       rst,                  // async reset
    input wire       ce,                   // clock enable
    input wire [7:0] addr,                 // bus address
    input wire       rd,                   // read strobe
    input wire [3:0] rdata_q,              // read data
    input wire       core_irq_enable_flag, // core enable
    input wire       halt_exec,            // halt pulse
    input wire       irq_req,              // request
    input wire [3:0] vector_step,          // vector step
    input wire [3:0] vector_page,          // vector page
    input wire       core_clock_en,        // core clock gate
    input wire       halted_q              // halted state
);
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
sequence s_halt; ce && halt_exec && !irq_req; endsequence
sequence s_wake; ce && halted_q && irq_req; endsequence
chk_req_needs_en: assert property (irq_req |-> core_irq_enable_flag)
    else $error("request without core enable");
chk_vec_idle: assert property (!irq_req |-> vector_step == 4'h0)
    else $error("vector step without request");
chk_vec_busy: assert property (irq_req |-> vector_step != 4'h0)
    else $error("request with empty vector step");
chk_vec_page: assert property (vector_page == 4'h1)
    else $error("vector page wrong");
chk_clock_gate: assert property (
    core_clock_en == (!halted_q || irq_req))
    else $error("core clock gate wrong");
chk_halt_enter: assert property (s_halt |=> halted_q)
    else $error("halt not entered");
chk_halt_wake: assert property (s_wake |=> !halted_q)
    else $error("halt not left on request");
chk_unused_d3: assert property (ce && rd && (addr == 8'h79 || addr == 8'h77)
    |=> !rdata_q[3])
    else $error("unused bit reads one");
chk_read_hold: assert property (!(ce && rd) |=> $stable(rdata_q))
    else $error("read data moved without read");
endmodule
bind interrupt_flag_mask_unit irq_unit_checker irq_unit_checker_i (
    .clock(clock), .rst(rst), .ce(ce), .addr(addr), .rd(rd),
    .rdata_q(rdata_q), .core_irq_enable_flag(core_irq_enable_flag),
    .halt_exec(halt_exec), .irq_req(irq_req), .vector_step(vector_step),
    .vector_page(vector_page), .core_clock_en(core_clock_en),
    .halted_q(halted_q));

// *** tb/core_model.sv ***
`timescale 1ns/1ps
module core_model (
    input  wire       clock,       // system clock
    input  wire       rst,         // initial reset
    input  wire       irq_req,     // request from unit
    input  wire [3:0] vector_step, // pending groups
    input  wire       irq_en_set,  // enable instruction
    output reg        irq_en_q,    // core enable flag
    output reg  [3:0] taken_vec_q  // last vector fetched
);
// taking an interrupt drops the enable flag
always @(posedge clock or posedge rst) begin
    if (rst) begin
        irq_en_q <= 1'b0;
        taken_vec_q <= 4'h0;
    end else if (irq_req) begin
        irq_en_q <= 1'b0;
        taken_vec_q <= vector_step;
    end else if (irq_en_set) begin
        irq_en_q <= 1'b1;
        taken_vec_q <= 4'h0;
    end
end
endmodule

// *** tb/interrupt_flag_mask_unit_tb.sv ***
`timescale 1ns/1ps
module interrupt_flag_mask_unit_tb;
reg clock = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
reg [7:0] addr = 8'h00;
reg [3:0] wdata = 4'h0, pins = 4'h0;
reg [4:0] taps = 5'h00;
reg single = 1'b0, halt_exec = 1'b0, low_v = 1'b0, irq_en_set = 1'b0;
wire [3:0] rdata_q, vector_step, vector_page, taken_vec;
wire irq_req, core_clock_en, halted_q, heavy, chk_on, drv_sw, irq_en;
integer mismatches = 0, compares = 0, cycles = 0, i;
always #50 clock = ~clock;
interrupt_flag_mask_unit interrupt_flag_mask_unit_i (.clock(clock),
    .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .input_pin_group(pins), .single_input_pin(single),
    .timer_2hz(taps[2]), .timer_8hz(taps[1]), .timer_32hz(taps[0]),
    .sw_1hz(taps[4]), .sw_10hz(taps[3]), .core_irq_enable_flag(irq_en),
    .halt_exec(halt_exec), .supply_low_result(low_v), .irq_req(irq_req),
    .vector_step(vector_step), .vector_page(vector_page),
    .core_clock_en(core_clock_en), .halted_q(halted_q),
    .heavy_load_mode(heavy), .supply_check_on(chk_on),
    .display_drive_switch(drv_sw));
core_model core_model_i (.clock(clock), .rst(rst), .irq_req(irq_req),
    .vector_step(vector_step), .irq_en_set(irq_en_set), .irq_en_q(irq_en),
    .taken_vec_q(taken_vec));
// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
task finish_test;
    begin
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
endtask
always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
        mismatches = mismatches + 1;
        finish_test;
    end
end
task check(input [3:0] seen, input [3:0] exp, input [8*10:1] name);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task wr_reg(input [7:0] a, input [3:0] d);
    begin
        @(negedge clock) addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock) wr = 1'b0;
    end
endtask
task rd_chk(input [7:0] a, input [3:0] exp);
    begin
        @(negedge clock) addr = a;
        rd = 1'b1;
        @(negedge clock) rd = 1'b0;
        check(rdata_q, exp, "rdata_q");
    end
endtask
task pulse_irq_en;
    begin
        @(negedge clock) irq_en_set = 1'b1;
        @(negedge clock) irq_en_set = 1'b0;
    end
endtask
task tap_fall(input integer n);
    begin
        @(negedge clock) taps[n] = 1'b1;
        repeat (4) @(negedge clock);
        taps[n] = 1'b0;
        repeat (5) @(negedge clock);
    end
endtask
// ----------------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------------
task test_regs;
    begin
        for (i = 0; i < 7; i = i + 1) rd_chk(8'h74 + i[7:0], 4'h0);
        rd_chk(8'h7B, 4'h0);
        low_v = 1'b1;
        for (i = 0; i < 7; i = i + 1) wr_reg(8'h74 + i[7:0], 4'hF);
        rd_chk(8'h74, 4'hF);
        rd_chk(8'h76, 4'hF);
        rd_chk(8'h77, 4'h6);
        rd_chk(8'h78, 4'hF);
        rd_chk(8'h79, 4'h0);
        check({heavy, chk_on, drv_sw, 1'b0}, 4'hE, "mode bits");
        @(negedge clock) ce = 1'b0;
        wr_reg(8'h75, 4'h0);
        ce = 1'b1;
        rd_chk(8'h75, 4'hF);
    end
endtask
task test_events;
    begin
        for (i = 0; i < 5; i = i + 1) begin
            tap_fall(i);
            check({3'h0, irq_req}, 4'h0, "irq_req");
            pulse_irq_en;
            repeat (2) @(negedge clock);
            check(taken_vec, i < 3 ? 4'h4 : 4'h8, "vector");
            rd_chk(i < 3 ? 8'h79 : 8'h7A, 4'h1 << (i % 3));
            rd_chk(i < 3 ? 8'h79 : 8'h7A, 4'h0);
        end
        wr_reg(8'h78, 4'h0);
        pulse_irq_en;
        tap_fall(2);
        check({3'h0, irq_req}, 4'h0, "irq_req");
        rd_chk(8'h79, 4'h4);
    end
endtask
task test_pins;
    begin
        wr_reg(8'h74, 4'h0);
        wr_reg(8'h75, 4'h1);
        @(negedge clock) pins = 4'h2;
        repeat (5) @(negedge clock);
        rd_chk(8'h7A, 4'h0);
        pins = 4'h3;
        repeat (5) @(negedge clock);
        rd_chk(8'h7A, 4'h4);
        single = 1'b1;
        repeat (5) @(negedge clock);
        rd_chk(8'h77, 4'h7);
        rd_chk(8'h7A, 4'h0);
        single = 1'b0;
        repeat (5) @(negedge clock);
        rd_chk(8'h7A, 4'h8);
    end
endtask
task test_halt;
    begin
        wr_reg(8'h78, 4'h1);
        pulse_irq_en;
        @(negedge clock) halt_exec = 1'b1;
        @(negedge clock) halt_exec = 1'b0;
        check({halted_q, core_clock_en, 2'h0}, 4'h8, "halt");
        tap_fall(0);
        check({halted_q, 3'h0}, 4'h0, "halted_q");
        check(taken_vec, 4'h4, "vector");
    end
endtask
task test_collide;
    begin
        rd_chk(8'h79, 4'h1);
        @(negedge clock) taps[0] = 1'b1;
        repeat (5) @(negedge clock);
        taps[0] = 1'b0;
        repeat (2) @(negedge clock);
        addr = 8'h79;
        rd = 1'b1;
        @(negedge clock) rd = 1'b0;
        check(rdata_q, 4'h0, "rdata_q");
        rd_chk(8'h79, 4'h1);
    end
endtask
initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    test_regs;
    test_events;
    test_pins;
    test_halt;
    test_collide;
    finish_test;
end
endmodule
